// ===== design/gpib_fmt_params.svh
`ifndef GPIB_FMT_PARAMS_SVH
`define GPIB_FMT_PARAMS_SVH

// delimiter selection codes
`define DELIM_CRLF_EOI 2'h0
`define DELIM_LF 2'h1
`define DELIM_EOI 2'h2
`define DELIM_CRLF 2'h3
`define DELIM_RESET `DELIM_CRLF

// header output enable after reset (1 = header on)
`define HDR_RESET 1'b1

// terminator characters
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A

// reply layout
`define REPLY_LEN 17
`define HDR_LEN 2
`define FIELD_LEN (`REPLY_LEN - `HDR_LEN)
`define SNAP_LEN 7

// reply data buffer
`define FIFO_W 8
`define FIFO_D 8

`endif

// ===== design/gpib_fmt_pkg.sv
`default_nettype none
package gpib_fmt_pkg;

    typedef logic [1:0] delim_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SNAP,
        S_HDR0,
        S_HDR1,
        S_FIELD,
        S_CR,
        S_LF
    } fmt_state_e;

endpackage
`default_nettype wire

// ===== design/gpib_response_formatter.sv
// What this block does
// - selection 1: end with LF, no EOI
// - selection 2: EOI with last data byte
// - selection 3: end with CR LF, no EOI
// - selection 0: CR LF, EOI on LF only
// - accept input ended by any delimiter form
// - delimiter-select command changes active selection
// - power-on delimiter selection is 3
// - snapshot is exactly seven binary bytes
// - snapshot sent once addressed as talker
// - snapshot: EOI on seventh, no CR LF
// - byte 1: attenuator 0 to 5
// - byte 2: vertical scale code 0 to 3
// - byte 3: reference unit code 0 to 7
// - byte 4: coarse 0, fine 1
// - byte 5: trigger mode code 0 to 3
// - byte 6: knob marker 0, centre 1
// - byte 7: frequency control off 0, on 1
// - header on: two letters precede field
// - header command: 0 disables, 1 enables
// - parameter reply is 17 bytes with header on, 15 field bytes with header off
`timescale 1ns/100ps
`default_nettype none
`include "gpib_fmt_params.svh"
////////////////////////////////////////////////////////////////////////////////
// reply data buffer
module reply_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // write side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // read side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = ce && in_valid && !full;
    wire pop = ce && out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// talker-side reply formatter
module gpib_response_formatter
    import gpib_fmt_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // commands from the parser, one-cycle strobes
    input wire logic delimiter_select_cmd,
    input wire logic [1:0] delimiter_value,
    input wire logic header_control_cmd,
    input wire logic header_arg,
    input wire logic parameter_query_cmd,
    input wire logic [15:0] parameter_header_code,
    input wire logic settings_snapshot_request,
    // front-panel settings
    input wire logic [2:0] atten_step,
    input wire logic [1:0] vert_scale,
    input wire logic [2:0] ref_unit,
    input wire logic ref_fine,
    input wire logic [1:0] trig_mode,
    input wire logic knob_on_cf,
    input wire logic auto_freq_control,
    // numeric field bytes from the reply generator
    input wire logic [7:0] field_data,
    input wire logic field_valid,
    output logic field_ready,
    // talker addressing, asynchronous pin level
    input wire logic talker_addressed,
    // talker byte port
    output logic [7:0] tx_data,
    output logic tx_eoi,
    output logic tx_valid,
    input wire logic tx_ready,
    // listener byte port and message end detection
    input wire logic [7:0] rx_data,
    input wire logic rx_eoi,
    input wire logic rx_valid,
    output logic rx_msg_end,
    // status
    output logic [1:0] delimiter_sel,
    output logic header_on,
    output logic reply_busy
);
    ////////////////////////////////////////////////////////////////////////////
    // talker addressing synchroniser: accept change once stages 2 and 3 agree
    logic talk_m1_q;
    logic talk_m2_q;
    logic talk_m3_q;
    logic talk_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            talk_m1_q <= 1'b0;
            talk_m2_q <= 1'b0;
            talk_m3_q <= 1'b0;
            talk_q <= 1'b0;
        end else if (ce) begin
            talk_m1_q <= talker_addressed;
            talk_m2_q <= talk_m1_q;
            talk_m3_q <= talk_m2_q;
            if (talk_m2_q == talk_m3_q) begin
                talk_q <= talk_m3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration
    delim_t delim_q;
    logic hdr_on_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            delim_q <= `DELIM_RESET;
            hdr_on_q <= `HDR_RESET;
        end else if (ce) begin
            if (delimiter_select_cmd) begin
                delim_q <= delimiter_value;
            end
            if (header_control_cmd) begin
                hdr_on_q <= header_arg;
            end
        end
    end
    assign delimiter_sel = delim_q;
    assign header_on = hdr_on_q;

    ////////////////////////////////////////////////////////////////////////////
    // incoming message end: LF alone, CR LF, or EOI on any byte
    logic rx_end_q;
    wire rx_end_d = rx_valid && (rx_eoi || rx_data == `CHAR_LF);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_end_q <= 1'b0;
        end else if (ce) begin
            rx_end_q <= rx_end_d;
        end
    end
    assign rx_msg_end = rx_end_q;

    ////////////////////////////////////////////////////////////////////////////
    // field buffer
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    reply_fifo #(
        .W(`FIFO_W),
        .D(`FIFO_D)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .in_data(field_data),
        .in_valid(field_valid),
        .in_ready(field_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // snapshot capture, frozen when the request is taken
    logic [7:0] snap_q [`SNAP_LEN];
    logic snap_pend_q;
    logic reply_pend_q;
    logic [15:0] hdr_code_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `SNAP_LEN; i++) begin
                snap_q[i] <= 8'h00;
            end
            hdr_code_q <= 16'h0000;
        end else if (ce) begin
            if (settings_snapshot_request) begin
                snap_q[0] <= {5'h00, atten_step};
                snap_q[1] <= {6'h00, vert_scale};
                snap_q[2] <= {5'h00, ref_unit};
                snap_q[3] <= {7'h00, ref_fine};
                snap_q[4] <= {6'h00, trig_mode};
                snap_q[5] <= {7'h00, knob_on_cf};
                snap_q[6] <= {7'h00, auto_freq_control};
            end
            if (parameter_query_cmd) begin
                hdr_code_q <= parameter_header_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output sequencer
    fmt_state_e state_q;
    fmt_state_e state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic out_vld_q;
    logic [7:0] out_data_q;
    logic out_eoi_q;
    // output register may take a new byte when empty or being drained
    wire slot_free = !out_vld_q || tx_ready;
    wire go = ce && talk_q && slot_free;
    wire snap_last = (cnt_q == 4'(`SNAP_LEN - 1));
    wire field_last = (cnt_q == 4'(`FIELD_LEN - 1));
    logic have_byte;
    logic [7:0] next_byte;
    logic next_eoi;
    logic snap_done;
    logic reply_done;
    always_comb begin
        have_byte = 1'b0;
        next_byte = 8'h00;
        next_eoi = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        snap_done = 1'b0;
        reply_done = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                // snapshot wins when both are waiting
                cnt_d = 4'h0;
                if (snap_pend_q) begin
                    state_d = S_SNAP;
                end else if (reply_pend_q) begin
                    state_d = hdr_on_q ? S_HDR0 : S_FIELD;
                end
            end
            S_SNAP: begin
                have_byte = 1'b1;
                next_byte = snap_q[cnt_q[2:0]];
                next_eoi = snap_last;
                if (snap_last) begin
                    state_d = S_IDLE;
                    snap_done = 1'b1;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            S_HDR0: begin
                have_byte = 1'b1;
                next_byte = hdr_code_q[15:8];
                state_d = S_HDR1;
            end
            S_HDR1: begin
                have_byte = 1'b1;
                next_byte = hdr_code_q[7:0];
                state_d = S_FIELD;
            end
            S_FIELD: begin
                have_byte = fifo_valid;
                next_byte = fifo_data;
                next_eoi = field_last && delim_q == `DELIM_EOI;
                if (!field_last) begin
                    cnt_d = cnt_q + 4'h1;
                end else if (delim_q == `DELIM_EOI) begin
                    state_d = S_IDLE;
                    reply_done = 1'b1;
                end else if (delim_q == `DELIM_LF) begin
                    state_d = S_LF;
                end else begin
                    state_d = S_CR;
                end
            end
            S_CR: begin
                have_byte = 1'b1;
                next_byte = `CHAR_CR;
                state_d = S_LF;
            end
            S_LF: begin
                have_byte = 1'b1;
                next_byte = `CHAR_LF;
                next_eoi = (delim_q == `DELIM_CRLF_EOI);
                state_d = S_IDLE;
                reply_done = 1'b1;
            end
        endcase
    end
    // a byte leaves the sequencer only while addressed and the port has room
    wire load = go && have_byte;
    wire step = (state_q == S_IDLE) ? ce : load;
    assign fifo_pop = load && state_q == S_FIELD;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
        end else if (step) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end
    // pending flags: a new request in the finishing cycle is kept
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            snap_pend_q <= 1'b0;
            reply_pend_q <= 1'b0;
        end else if (ce) begin
            if (settings_snapshot_request) begin
                snap_pend_q <= 1'b1;
            end else if (load && snap_done) begin
                snap_pend_q <= 1'b0;
            end
            if (parameter_query_cmd) begin
                reply_pend_q <= 1'b1;
            end else if (load && reply_done) begin
                reply_pend_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_vld_q <= 1'b0;
            out_data_q <= 8'h00;
            out_eoi_q <= 1'b0;
        end else if (ce) begin
            if (load) begin
                out_vld_q <= 1'b1;
                out_data_q <= next_byte;
                out_eoi_q <= next_eoi;
            end else if (tx_ready) begin
                out_vld_q <= 1'b0;
            end
        end
    end
    assign tx_data = out_data_q;
    assign tx_eoi = out_eoi_q;
    assign tx_valid = out_vld_q;
    assign reply_busy = snap_pend_q || reply_pend_q || state_q != S_IDLE;
endmodule

`default_nettype wire

// ===== testbench/gpib_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// controller in listener role; logs every byte with its end flag
module gpib_ctrl_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // talker port of the device
    input wire logic [7:0] tx_data,
    input wire logic tx_eoi,
    input wire logic tx_valid,
    output logic tx_ready,
    // stall request from the bench
    input wire logic stall
);
    logic [8:0] got_q[$];
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready <= 1'h0;
        end else begin
            if (tx_valid && tx_ready) begin
                got_q.push_back({tx_eoi, tx_data});
            end
            tx_ready <= stall ? ($urandom_range(0, 3) != 0) : 1'h1;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/gpib_response_formatter_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpib_fmt_params.svh"
module formatter_chk (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // commands
    input wire logic delimiter_select_cmd,
    input wire logic [1:0] delimiter_value,
    input wire logic header_control_cmd,
    input wire logic header_arg,
    // byte ports
    input wire logic [7:0] tx_data,
    input wire logic tx_eoi,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_eoi,
    input wire logic rx_valid,
    input wire logic rx_msg_end,
    // status
    input wire logic [1:0] delimiter_sel,
    input wire logic header_on
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    wire logic rx_end = ce && rx_valid && (rx_data == `CHAR_LF || rx_eoi);
    wire logic tx_lf = tx_valid && tx_data == `CHAR_LF;
    wire logic tx_cr = tx_valid && tx_data == `CHAR_CR;
    property p_delim_load;
        ce && delimiter_select_cmd |=> delimiter_sel == $past(delimiter_value);
    endproperty
    a_delim_load: assert property (p_delim_load) else $error("selection not loaded");
    property p_delim_hold;
        !(ce && delimiter_select_cmd) |=> $stable(delimiter_sel);
    endproperty
    a_delim_hold: assert property (p_delim_hold) else $error("selection moved");
    property p_hdr_load;
        ce && header_control_cmd |=> header_on == $past(header_arg);
    endproperty
    a_hdr_load: assert property (p_hdr_load) else $error("header flag wrong");
    property p_lf_eoi;
        tx_lf && delimiter_sel == `DELIM_CRLF_EOI |-> tx_eoi;
    endproperty
    a_lf_eoi: assert property (p_lf_eoi) else $error("end flag missing on LF");
    property p_term_plain;
        tx_cr || (tx_lf && delimiter_sel != `DELIM_CRLF_EOI) |-> !tx_eoi;
    endproperty
    a_term_plain: assert property (p_term_plain) else $error("end flag on plain end");
    property p_tx_hold;
        ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eoi);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("byte dropped in stall");
    property p_rx_end;
        rx_end |=> rx_msg_end;
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("message end missed");
    property p_rx_quiet;
        ce && !rx_end |=> !rx_msg_end;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("false message end");
    c_stall: cover property (tx_valid && !tx_ready);
    c_eoi_lf: cover property (tx_lf && tx_eoi);
    c_rx_end: cover property (rx_end);
endmodule
bind gpib_response_formatter formatter_chk u_chk (.clk_sys, .rst_b, .ce, .delimiter_select_cmd,
    .delimiter_value, .header_control_cmd, .header_arg, .tx_data, .tx_eoi, .tx_valid,
    .tx_ready, .rx_data, .rx_eoi, .rx_valid, .rx_msg_end, .delimiter_sel, .header_on);
`default_nettype wire

// ===== testbench/test_gpib_response_formatter.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpib_fmt_params.svh"
module test_gpib_response_formatter;
    logic clk_sys = 1'h0, rst_b = 1'h0, ce = 1'h1, stall = 1'h0, talker_addressed = 1'h0;
    logic delimiter_select_cmd = 1'h0, header_control_cmd = 1'h0, header_arg = 1'h0;
    logic parameter_query_cmd = 1'h0, settings_snapshot_request = 1'h0, field_valid = 1'h0;
    logic ref_fine = 1'h0, knob_on_cf = 1'h0, auto_freq_control = 1'h0;
    logic rx_eoi = 1'h0, rx_valid = 1'h0;
    logic [1:0] delimiter_value = 2'h0, vert_scale = 2'h0, trig_mode = 2'h0, delimiter_sel;
    logic [2:0] atten_step = 3'h0, ref_unit = 3'h0;
    logic [15:0] parameter_header_code = 16'h0;
    logic [7:0] field_data = 8'h0, rx_data = 8'h0, tx_data;
    logic tx_eoi, tx_valid, tx_ready, field_ready, rx_msg_end, header_on, reply_busy;
    logic [8:0] exp_q[$];
    int n_mismatch = 0;
    int tests_run = 0;
    always #5 clk_sys = ~clk_sys;
    gpib_response_formatter dut (.clk_sys, .rst_b, .ce, .delimiter_select_cmd,
        .delimiter_value, .header_control_cmd, .header_arg, .parameter_query_cmd,
        .parameter_header_code, .settings_snapshot_request, .atten_step, .vert_scale,
        .ref_unit, .ref_fine, .trig_mode, .knob_on_cf, .auto_freq_control, .field_data,
        .field_valid, .field_ready, .talker_addressed, .tx_data, .tx_eoi, .tx_valid,
        .tx_ready, .rx_data, .rx_eoi, .rx_valid, .rx_msg_end, .delimiter_sel, .header_on,
        .reply_busy);
    gpib_ctrl_model ctl (.clk_sys, .rst_b, .tx_data, .tx_eoi, .tx_valid, .tx_ready, .stall);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // expected field byte: end flag only on the last byte under the eoi delimiter
    function automatic logic [8:0] field_byte(input logic [1:0] d, input int i,
        input logic [7:0] v);
        return {d == `DELIM_EOI && i == `FIELD_LEN - 1, v};
    endfunction
    // busy drops when the last byte is loaded, so also wait for the port to drain
    task automatic wait_done;
        int i;
        for (i = 0; i < 500; i++) begin
            @(posedge clk_sys);
            #1;
            if (reply_busy === 1'h0 && tx_valid === 1'h0) break;
        end
        if (i == 500) begin
            n_mismatch++;
            print_verdict();
        end
        chk(9'(ctl.got_q.size()), 9'(exp_q.size()));
        foreach (exp_q[k]) if (k < ctl.got_q.size()) chk(ctl.got_q[k], exp_q[k]);
        ctl.got_q.delete();
        exp_q.delete();
    endtask
    task automatic snapshot(input int k);
        @(posedge clk_sys);
        atten_step <= (k == 0) ? 3'h5 : 3'($urandom_range(0, 5));
        {vert_scale, trig_mode} <= (k == 0) ? 4'hF : 4'($urandom);
        {ref_unit, ref_fine, knob_on_cf, auto_freq_control} <= (k == 0) ? 6'h3F : 6'($urandom);
        stall <= k[0];
        @(posedge clk_sys);
        settings_snapshot_request <= 1'h1;
        @(posedge clk_sys);
        settings_snapshot_request <= 1'h0;
        exp_q = '{{6'h0, atten_step}, {7'h0, vert_scale}, {6'h0, ref_unit}, {8'h0, ref_fine},
            {7'h0, trig_mode}, {8'h0, knob_on_cf}, {1'h1, 7'h0, auto_freq_control}};
        // panel moves right after the request; the reply must not follow it
        {ref_unit, vert_scale, knob_on_cf} <= ~{ref_unit, vert_scale, knob_on_cf};
        wait_done();
    endtask
    task automatic query(input logic [1:0] d, input logic h);
        int i, j;
        logic r;
        logic [7:0] v;
        @(posedge clk_sys);
        talker_addressed <= 1'h0;
        stall <= d[1];
        repeat (5) @(posedge clk_sys);
        delimiter_select_cmd <= 1'h1;
        delimiter_value <= d;
        header_control_cmd <= 1'h1;
        header_arg <= h;
        @(posedge clk_sys);
        {delimiter_select_cmd, header_control_cmd, parameter_query_cmd} <= 3'h1;
        parameter_header_code <= {8'h41 + 8'($urandom_range(0, 25)), 8'h5A};
        @(posedge clk_sys);
        parameter_query_cmd <= 1'h0;
        #1;
        chk({7'h0, delimiter_sel}, {7'h0, d});
        chk({8'h0, header_on}, {8'h0, h});
        if (h) exp_q = '{{1'h0, parameter_header_code[15:8]}, {1'h0, parameter_header_code[7:0]}};
        @(posedge clk_sys);
        // the first eight bytes go in while muted, so the buffer must fill and refuse
        for (i = 0; i < `FIELD_LEN; i++) begin
            v = 8'h30 + 8'($urandom_range(0, 9));
            field_valid <= 1'h1;
            field_data <= v;
            if (i == 8) talker_addressed <= 1'h1;
            for (j = 0; j < 60; j++) begin
                @(negedge clk_sys);
                r = field_ready;
                if (i == 8 && j == 0) chk({8'h0, r}, 9'h0);
                @(posedge clk_sys);
                if (r) break;
            end
            if (j == 60) begin
                n_mismatch++;
                print_verdict();
            end
            exp_q.push_back(field_byte(d, i, v));
        end
        field_valid <= 1'h0;
        if (d == `DELIM_CRLF || d == `DELIM_CRLF_EOI) exp_q.push_back({1'h0, `CHAR_CR});
        if (d != `DELIM_EOI) exp_q.push_back({d == `DELIM_CRLF_EOI, `CHAR_LF});
        wait_done();
    endtask
    task automatic rx_send(input logic [8:0] b, input logic e);
        @(posedge clk_sys);
        {rx_eoi, rx_data} <= b;
        rx_valid <= 1'h1;
        @(posedge clk_sys);
        {rx_valid, rx_eoi} <= 2'h0;
        #1;
        chk({8'h0, rx_msg_end}, {8'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h8BE1F18A));
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        @(posedge clk_sys);
        #1;
        chk({7'h0, delimiter_sel}, {7'h0, `DELIM_RESET});
        chk({8'h0, header_on}, {8'h0, `HDR_RESET});
        for (int d = 3; d >= 0; d--) begin
            for (int h = 0; h < 2; h++) query(2'(d), 1'(h));
        end
        for (int k = 0; k < 4; k++) snapshot(k);
        rx_send(9'h041, 1'h0);
        rx_send({1'h0, `CHAR_CR}, 1'h0);
        rx_send({1'h0, `CHAR_LF}, 1'h1);
        rx_send(9'h141, 1'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
